/* File: src/micropower_adc_serial_port.sv */
// Serial control and data port of a 12-bit sampling converter, with its result buffer
`timescale 1ns/100ps

module result_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             flush_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  output logic      [WIDTH-1:0] rd_data_o,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ptr_ff;
  logic [AW:0]      rd_ptr_ff;
  logic [AW:0]      nxt_wr_ptr;
  logic [AW:0]      nxt_rd_ptr;
  logic             do_wr;
  logic             do_rd;

  // Full when pointers differ only in the wrap bit
  assign wr_ready_o = ((wr_ptr_ff ^ rd_ptr_ff) != {1'b1, {AW{1'b0}}});
  assign rd_valid_o = (wr_ptr_ff != rd_ptr_ff);
  assign rd_data_o  = mem_ff[rd_ptr_ff[AW-1:0]];
  assign do_wr      = wr_valid_i && wr_ready_o && !flush_i;
  assign do_rd      = rd_valid_o && rd_ready_i && !flush_i;

  // Pointer advance, flush empties the buffer
  always_comb begin
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = flush_i ? wr_ptr_ff : rd_ptr_ff;
    if (do_wr) begin
      nxt_wr_ptr = wr_ptr_ff + 1'b1;
    end
    if (do_rd) begin
      nxt_rd_ptr = rd_ptr_ff + 1'b1;
    end
  end

  // Pointer registers and storage, words need no reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      if (do_wr) begin
        mem_ff[wr_ptr_ff[AW-1:0]] <= wr_data_i;
      end
    end
  end
endmodule

module micropower_adc_serial_port (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        two_channel_i,
  input  wire logic        select_and_shutdown_n_i,
  input  wire logic        shift_clk_i,
  input  wire logic        din_i,
  output logic             dout_o,
  output logic             dout_oe_o,
  output logic             port_power_o,
  output logic             bias_enable_o,
  output logic             sample_o,
  output logic             conv_start_o,
  output logic             single_ended_select_o,
  output logic             odd_sign_o,
  output logic             result_order_bit_o,
  output logic             pos_is_channel_one_o,
  output logic             neg_is_ground_o,
  output logic             neg_is_channel_one_o,
  input  wire logic [11:0] conv_data_i,
  input  wire logic        conv_valid_i,
  output logic             conv_ready_o
);
  adc_port_pkg::port_state_t state_ff;
  adc_port_pkg::port_state_t nxt_state;
  logic        sclk_ff;
  logic [3:0]  bitcnt_ff;
  logic [3:0]  nxt_bitcnt;
  logic [1:0]  cfgcnt_ff;
  logic [1:0]  nxt_cfgcnt;
  logic [2:0]  fallcnt_ff;
  logic [2:0]  nxt_fallcnt;
  logic [2:0]  cfg_ff;
  logic [2:0]  nxt_cfg;
  logic [11:0] shreg_ff;
  logic [11:0] nxt_shreg;
  logic        dout_ff;
  logic        nxt_dout;
  logic        oe_ff;
  logic        nxt_oe;
  logic        sample_ff;
  logic        nxt_sample;
  logic        bias_ff;
  logic        nxt_bias;
  logic        start_ff;
  logic        nxt_start;
  logic        clk_rise;
  logic        clk_fall;
  logic        reverse;
  logic [2:0]  en_falls;
  logic        fifo_pop;
  logic        fifo_valid;
  logic [11:0] fifo_data;

  // Shift clock edges from the previous sample
  assign clk_rise = shift_clk_i && !sclk_ff;
  assign clk_fall = !shift_clk_i && sclk_ff;
  assign reverse  = !two_channel_i || !cfg_ff[0];
  assign en_falls = two_channel_i ? adc_port_pkg::EN_FALLS_TWO
                                  : adc_port_pkg::EN_FALLS_ONE;
  assign fifo_pop = (state_ff == adc_port_pkg::ST_NULLB) && clk_fall &&
                    !select_and_shutdown_n_i;

  // Results from the converter core pass through the buffer
  result_fifo #(
    .WIDTH (adc_port_pkg::RESULT_W),
    .DEPTH (adc_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .flush_i    (select_and_shutdown_n_i),
    .wr_data_i  (conv_data_i),
    .wr_valid_i (conv_valid_i),
    .wr_ready_o (conv_ready_o),
    .rd_data_o  (fifo_data),
    .rd_valid_o (fifo_valid),
    .rd_ready_i (fifo_pop)
  );

  // Sequencer next values
  always_comb begin
    nxt_state   = state_ff;
    nxt_bitcnt  = bitcnt_ff;
    nxt_cfgcnt  = cfgcnt_ff;
    nxt_fallcnt = fallcnt_ff;
    nxt_cfg     = cfg_ff;
    nxt_shreg   = shreg_ff;
    nxt_dout    = dout_ff;
    nxt_oe      = oe_ff;
    nxt_sample  = sample_ff;
    nxt_bias    = bias_ff;
    nxt_start   = 1'b0;
    if (select_and_shutdown_n_i) begin
      nxt_state   = adc_port_pkg::ST_IDLE;
      nxt_bitcnt  = adc_port_pkg::LSB_IDX;
      nxt_cfgcnt  = '0;
      nxt_fallcnt = '0;
      nxt_cfg     = adc_port_pkg::CFG_RST;
      nxt_shreg   = adc_port_pkg::RESULT_RST;
      nxt_dout    = 1'b0;
      nxt_oe      = 1'b0;
      nxt_sample  = 1'b0;
      nxt_bias    = 1'b0;
    end else begin
      unique case (state_ff)
        adc_port_pkg::ST_IDLE: begin
          if (clk_rise && !two_channel_i) begin
            nxt_state   = adc_port_pkg::ST_SAMPLE;
            nxt_sample  = 1'b1;
            nxt_bias    = 1'b1;
          end else if (clk_rise && din_i) begin
            nxt_state   = adc_port_pkg::ST_CFG;
          end
        end
        adc_port_pkg::ST_CFG: begin
          if (clk_rise) begin
            nxt_cfg    = {cfg_ff[1:0], din_i};
            nxt_cfgcnt = cfgcnt_ff + 2'h1;
            if (cfgcnt_ff == adc_port_pkg::CFG_SMPL_IDX) begin
              nxt_sample = 1'b1;
              nxt_bias   = 1'b1;
            end
            if (cfgcnt_ff == adc_port_pkg::CFG_LAST_IDX) begin
              nxt_state = adc_port_pkg::ST_SAMPLE;
            end
          end else if (clk_fall) begin
            nxt_fallcnt = fallcnt_ff + 3'h1;
          end
        end
        adc_port_pkg::ST_SAMPLE: begin
          if (clk_fall) begin
            nxt_fallcnt = fallcnt_ff + 3'h1;
            if (nxt_fallcnt == en_falls) begin
              nxt_state  = adc_port_pkg::ST_NULLB;
              nxt_oe     = 1'b1;
              nxt_sample = 1'b0;
              nxt_start  = 1'b1;
            end
          end
        end
        adc_port_pkg::ST_NULLB: begin
          if (clk_fall) begin
            nxt_state  = adc_port_pkg::ST_RESULT_ORDER_BIT;
            nxt_shreg  = fifo_valid ? fifo_data : adc_port_pkg::RESULT_RST;
            nxt_dout   = nxt_shreg[adc_port_pkg::MSB_IDX];
          end
        end
        adc_port_pkg::ST_RESULT_ORDER_BIT: begin
          if (clk_fall) begin
            if (bitcnt_ff == adc_port_pkg::MSB_IDX) begin
              nxt_bias = 1'b0;
              if (reverse) begin
                nxt_state  = adc_port_pkg::ST_LSBF;
                nxt_bitcnt = adc_port_pkg::LSBF_FIRST;
                nxt_dout   = shreg_ff[adc_port_pkg::LSBF_FIRST];
              end else begin
                nxt_state = adc_port_pkg::ST_ZEROS;
                nxt_dout  = 1'b0;
              end
            end else begin
              nxt_bitcnt = bitcnt_ff + 4'h1;
              nxt_dout   = shreg_ff[adc_port_pkg::MSB_IDX - nxt_bitcnt];
            end
          end
        end
        adc_port_pkg::ST_LSBF: begin
          if (clk_fall) begin
            if (bitcnt_ff == adc_port_pkg::MSB_IDX) begin
              nxt_state = adc_port_pkg::ST_ZEROS;
              nxt_dout  = 1'b0;
            end else begin
              nxt_bitcnt = bitcnt_ff + 4'h1;
              nxt_dout   = shreg_ff[nxt_bitcnt];
            end
          end
        end
        adc_port_pkg::ST_ZEROS: nxt_dout = 1'b0;
        default: nxt_state = adc_port_pkg::ST_IDLE;
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff   <= adc_port_pkg::ST_IDLE;
      sclk_ff    <= 1'b0;
      bitcnt_ff  <= adc_port_pkg::LSB_IDX;
      cfgcnt_ff  <= '0;
      fallcnt_ff <= '0;
      cfg_ff     <= adc_port_pkg::CFG_RST;
      shreg_ff   <= adc_port_pkg::RESULT_RST;
      dout_ff    <= 1'b0;
      oe_ff      <= 1'b0;
      sample_ff  <= 1'b0;
      bias_ff    <= 1'b0;
      start_ff   <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      sclk_ff    <= shift_clk_i;
      bitcnt_ff  <= nxt_bitcnt;
      cfgcnt_ff  <= nxt_cfgcnt;
      fallcnt_ff <= nxt_fallcnt;
      cfg_ff     <= nxt_cfg;
      shreg_ff   <= nxt_shreg;
      dout_ff    <= nxt_dout;
      oe_ff      <= nxt_oe;
      sample_ff  <= nxt_sample;
      bias_ff    <= nxt_bias;
      start_ff   <= nxt_start;
    end
  end

  // Output pins and converter controls
  assign dout_o                = dout_ff;
  assign dout_oe_o             = oe_ff;
  assign port_power_o          = !select_and_shutdown_n_i;
  assign bias_enable_o         = bias_ff;
  assign sample_o              = sample_ff;
  assign conv_start_o          = start_ff;
  assign single_ended_select_o = cfg_ff[2];
  assign odd_sign_o            = cfg_ff[1];
  assign result_order_bit_o    = cfg_ff[0];
  assign pos_is_channel_one_o  = cfg_ff[1];
  assign neg_is_ground_o       = cfg_ff[2];
  assign neg_is_channel_one_o  = !cfg_ff[2] && !cfg_ff[1];

  // Checks on the port behaviour
  chk_undriven_when_high: assert property (@(posedge mclk_i) disable iff (rst_i)
    select_and_shutdown_n_i |=> !dout_oe_o) else $error("output driven while deselected");
  chk_change_on_fall: assert property (@(posedge mclk_i) disable iff (rst_i)
    $changed(dout_o) |-> $past(clk_fall) || $past(select_and_shutdown_n_i))
    else $error("output changed off a falling edge");
  chk_enable_on_fall: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(dout_oe_o) |-> $past(clk_fall) && !dout_o && conv_start_o)
    else $error("output enabled without null bit");
  chk_sample_to_conv: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(sample_o) && !$past(select_and_shutdown_n_i) |-> conv_start_o)
    else $error("sampling ended without conversion start");
  chk_cfg_frozen: assert property (@(posedge mclk_i) disable iff (rst_i)
    !select_and_shutdown_n_i && (state_ff inside {adc_port_pkg::ST_SAMPLE,
    adc_port_pkg::ST_NULLB, adc_port_pkg::ST_RESULT_ORDER_BIT, adc_port_pkg::ST_LSBF,
    adc_port_pkg::ST_ZEROS}) |=> $stable(cfg_ff)) else $error("configuration changed late");
  chk_zero_fill: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_ff == adc_port_pkg::ST_ZEROS |-> !dout_o && dout_oe_o && !bias_enable_o)
    else $error("zero fill broken");
  chk_pop_on_null: assert property (@(posedge mclk_i) disable iff (rst_i)
    fifo_pop |=> state_ff == adc_port_pkg::ST_RESULT_ORDER_BIT &&
    dout_o == ($past(fifo_valid) && $past(fifo_data[11]))) else $error("result load wrong");
  chk_top_first_end: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_ff == adc_port_pkg::ST_RESULT_ORDER_BIT && clk_fall && bitcnt_ff == adc_port_pkg::MSB_IDX &&
    !select_and_shutdown_n_i |=> (state_ff == adc_port_pkg::ST_LSBF) == reverse)
    else $error("order bit not honoured");
endmodule

/* File: shared/adc_port_pkg.sv */
// Constants and types for the converter serial port
package adc_port_pkg;
  localparam int unsigned RESULT_W     = 12;      // Conversion result width
  localparam int unsigned CFG_W        = 3;       // Configuration word width
  localparam int unsigned FIFO_DEPTH   = 4;       // Result buffer depth in words
  localparam logic [3:0]  MSB_IDX      = 4'hB;    // Index of the top result bit
  localparam logic [3:0]  LSB_IDX      = 4'h0;    // Index of the lowest result bit
  localparam logic [3:0]  LSBF_FIRST   = 4'h1;    // First index sent in reversed order
  localparam logic [1:0]  CFG_LAST_IDX = 2'h2;    // Count of the order bit
  localparam logic [1:0]  CFG_SMPL_IDX = 2'h1;    // Count of the bit that opens sampling
  localparam logic [2:0]  EN_FALLS_ONE = 3'h2;    // Falls after first rise to drive, one input
  localparam logic [2:0]  EN_FALLS_TWO = 3'h4;    // Falls after start bit to drive, two inputs
  localparam logic [2:0]  CFG_RST      = 3'h0;    // Configuration after reset
  localparam logic [11:0] RESULT_RST   = 12'h000; // Result shifter after reset

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CFG    = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_NULLB  = 3'b011,
    ST_RESULT_ORDER_BIT   = 3'b100,
    ST_LSBF   = 3'b101,
    ST_ZEROS  = 3'b110
  } port_state_t;
endpackage

/* File: test/conv_core_model.sv */
// Converter core stand-in that answers each conversion start with one result word, or streams words while flood_i is set
`timescale 1ns/100ps

module conv_core_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        conv_start_i,
  input  wire logic        conv_ready_i,
  input  wire logic [11:0] word_i,
  input  wire logic [3:0]  delay_i,
  input  wire logic        flood_i,
  output logic      [11:0] conv_data_o,
  output logic             conv_valid_o
);
  logic [4:0] wait_ff;

  // One word per start after a delay, or back to back under flood_i, each held until taken
  always @(posedge mclk_i) begin
    if (rst_i) begin
      conv_valid_o <= 1'b0;
      conv_data_o  <= 12'hA5A;
      wait_ff      <= 5'h00;
    end else if (conv_valid_o) begin
      if (conv_ready_i) begin
        conv_valid_o <= flood_i;
        conv_data_o  <= flood_i ? conv_data_o + 12'h001 : ~conv_data_o;
      end
    end else if (flood_i || wait_ff == 5'h01) begin
      conv_valid_o <= 1'b1;
      conv_data_o  <= word_i;
      wait_ff      <= 5'h00;
    end else begin
      conv_data_o <= ~conv_data_o; // Idle data never holds still
      if (conv_start_i) wait_ff <= {1'b0, delay_i} + 5'h01;
      else if (wait_ff != 5'h00) wait_ff <= wait_ff - 5'h01;
    end
  end
endmodule

/* File: test/tb.sv */
// Self-checking bench for the converter serial port
`timescale 1ns/100ps

module tb;
  logic        mclk_i, rst_i, two_ch, cs_n, sclk, din, flood;
  logic [11:0] word, conv_data;
  logic [3:0]  delay;
  logic        conv_valid, conv_start, conv_ready;
  logic        dout_o, dout_oe_o, port_power_o, bias_enable_o, sample_o;
  logic        sgl_o, odd_o, ord_o, pos_one_o, neg_gnd_o, neg_one_o;
  int          mismatches, compares, i, starts;
  integer      seed;
  logic [31:0] rnd;

  micropower_adc_serial_port DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .two_channel_i(two_ch),
    .select_and_shutdown_n_i(cs_n), .shift_clk_i(sclk), .din_i(din),
    .dout_o(dout_o), .dout_oe_o(dout_oe_o), .port_power_o(port_power_o),
    .bias_enable_o(bias_enable_o), .sample_o(sample_o), .conv_start_o(conv_start),
    .single_ended_select_o(sgl_o), .odd_sign_o(odd_o), .result_order_bit_o(ord_o),
    .pos_is_channel_one_o(pos_one_o), .neg_is_ground_o(neg_gnd_o),
    .neg_is_channel_one_o(neg_one_o), .conv_data_i(conv_data),
    .conv_valid_i(conv_valid), .conv_ready_o(conv_ready));

  conv_core_model core (
    .mclk_i(mclk_i), .rst_i(rst_i), .conv_start_i(conv_start), .conv_ready_i(conv_ready),
    .word_i(word), .delay_i(delay), .flood_i(flood),
    .conv_data_o(conv_data), .conv_valid_o(conv_valid));

  // 40 MHz system clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Conversion start pulses, counted away from the launching edge
  always @(negedge mclk_i) begin
    if (conv_start === 1'b1) starts++;
  end

  // Compare and count
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test;
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Expected {enable, data} after k falls, null bit at fall n0
  function automatic logic [1:0] exp_bit(int k, int n0, logic [11:0] w, logic rev);
    if (k < n0) return 2'b00;
    if (k == n0) return 2'b10;
    if (k <= n0 + 12) return {1'b1, w[11 - (k - n0 - 1)]};
    if (rev && k <= n0 + 23) return {1'b1, w[k - n0 - 12]};
    return 2'b10;
  endfunction

  // One exchange: lead zeros, start, config, then read until fall count last
  task automatic xfer(input logic two, input logic [2:0] cfg, input int lead,
                      input logic [11:0] w, input int last);
    int n0, k, s0;
    logic tied;
    two_ch = two;
    word   = w;
    rnd    = $random(seed);
    delay  = {2'h0, rnd[1:0]};
    tied   = rnd[2]; // Host joins its data pins on some exchanges
    s0     = starts;
    cs_n   = 1'b0;
    repeat (3) @(negedge mclk_i);
    check(12'(port_power_o), 12'h001);
    n0 = two ? 4 : 2;
    for (k = two ? -lead : 0; k <= last; k++) begin
      rnd  = $random(seed);
      din  = (k < 0) ? 1'b0 : (k == 0 && two) ? 1'b1 : (k >= 1 && k <= 3) ? cfg[3 - k] :
             (tied ? dout_o : rnd[0]);
      sclk = 1'b1;
      repeat (4) @(negedge mclk_i);
      check(12'({dout_oe_o, dout_o}), 12'(exp_bit(k, n0, w, !two | !cfg[0])));
      if (k == n0) check(12'(bias_enable_o), 12'h001);
      if (k == n0 - 1 || k == n0) check(12'(sample_o), 12'(k == n0 - 1));
      sclk = 1'b0;
      repeat (4) @(negedge mclk_i);
    end
    if (last > n0 + 13) check(12'(bias_enable_o), 12'h000);
    check(12'(starts - s0), 12'h001);
    if (two) begin
      check(12'({sgl_o, odd_o, ord_o}), 12'(cfg));
      check(12'({pos_one_o, neg_gnd_o, neg_one_o}), 12'({cfg[1], cfg[2], !cfg[2] & !cfg[1]}));
    end
    cs_n = 1'b1;
    repeat (3) @(negedge mclk_i);
    check(12'({dout_oe_o, port_power_o}), 12'h000);
  endtask

  // Main sequence
  initial begin
    seed       = 32'h03a1;
    mismatches = 0;
    compares   = 0;
    rst_i      = 1'b1;
    two_ch     = 1'b0;
    cs_n       = 1'b1;
    sclk       = 1'b0;
    din        = 1'b0;
    flood      = 1'b0;
    word       = 12'h000;
    delay      = 4'h0;
    repeat (3) @(negedge mclk_i);
    rst_i = 1'b0;
    @(negedge mclk_i);
    check(12'({dout_oe_o, conv_ready}), 12'h001);
    // One-input exchanges, the second one cut right after the lowest bit
    xfer(1'b0, 3'h0, 0, 12'hFFF, 32);
    xfer(1'b0, 3'h0, 0, 12'h801, 14);
    xfer(1'b0, 3'h0, 0, 12'h001, 32);
    // Every configuration code, with random leading zeros and words
    for (i = 0; i < 16; i++) begin
      rnd = $random(seed);
      xfer(1'b1, i[2:0], int'(rnd[13:12]), rnd[11:0], 34);
    end
    // Buffer filled until it refuses, then one word drained through a transfer
    cs_n  = 1'b0;
    word  = 12'h3C5;
    flood = 1'b1;
    repeat (10) @(negedge mclk_i);
    check(12'(conv_ready), 12'h000);
    xfer(1'b0, 3'h0, 0, 12'h3C5, 20);
    flood = 1'b0;
    repeat (3) @(negedge mclk_i);
    check(12'(conv_ready), 12'h001);
    finish_test;
  end

  // Hang guard
  initial begin
    #(25.0 * 60000);
    mismatches++;
    finish_test;
  end
endmodule
